// ==== rtl/icw_consts.svh ====
`ifndef ICW_CONSTS_SVH
`define ICW_CONSTS_SVH

// configuration offsets (byte addresses within the function's space)
`define ICW_PTR_OFFSET      12'h0f8
`define ICW_DATA_OFFSET     12'h0fc

// pointer fields
`define ICW_BASE_LSB        2
`define ICW_BASE_MSB        7
`define ICW_EXT_LSB         8
`define ICW_EXT_MSB         11

// reset values
`define ICW_PTR_RESET       32'h0000_0000
`define ICW_DATA_RESET      32'h0000_0000

// dword index of the two window registers; not referenced, self-pointing is not guarded
`define ICW_PTR_DWORD       10'h03e
`define ICW_DATA_DWORD      10'h03f

`endif

// ==== rtl/icw_pkg.sv ====
`default_nettype none
package icw_pkg;
    typedef logic [9:0]  icw_dword_t;
    typedef logic [31:0] icw_word_t;
    typedef logic [3:0]  icw_be_t;
    typedef enum logic [2:0] {
        ICW_IDLE  = 3'b001,
        ICW_FWD   = 3'b010,
        ICW_DONE  = 3'b100
    } icw_state_t;
endpackage
`default_nettype wire

// ==== rtl/icw_pointer_reg.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "icw_consts.svh"

module icw_pointer_reg (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    // write port
    input  wire logic         wr_in,
    input  wire logic [3:0]   be_in,
    input  wire logic [31:0]  wdata_in,
    // pointer contents
    output logic [31:0]       ptr_out,
    output logic [9:0]        dword_out
);
    logic [5:0] base_num;
    logic [3:0] extended_register_number;
    logic [5:0] next_base_num;
    logic [3:0] next_extended_register_number;

    always_comb begin
        next_base_num = base_num;
        next_extended_register_number = extended_register_number;
        if (wr_in && be_in[0]) begin
            next_base_num = wdata_in[`ICW_BASE_MSB:`ICW_BASE_LSB]; // RULE1
        end
        if (wr_in && be_in[1]) begin
            next_extended_register_number = wdata_in[`ICW_EXT_MSB:`ICW_EXT_LSB]; // RULE2
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            base_num <= 6'(`ICW_PTR_RESET >> `ICW_BASE_LSB); // RULE9
            extended_register_number <= 4'(`ICW_PTR_RESET >> `ICW_EXT_LSB); // RULE9
        end else begin
            base_num <= next_base_num;
            extended_register_number <= next_extended_register_number;
        end
    end

    // reserved bits stay zero whatever is written
    assign ptr_out   = {20'h00000, extended_register_number, base_num, 2'h0}; // RULE10
    assign dword_out = {extended_register_number, base_num}; // RULE10
endmodule
`default_nettype wire

// ==== rtl/icw_window.sv ====
// Functional notes
// [RULE1] pointer bits 7:2 hold base dword number
// [RULE2] pointer bits 11:8 hold extended number
// [RULE3] software never points at window registers
// [RULE4] software never points at global-space registers
// [RULE5] data port read returns selected register
// [RULE6] data port write updates selected register
// [RULE7] data port byte enables forwarded unchanged
// [RULE8] smbus data port: read zero, write ignored
// [RULE9] pointer 0x0f8, data 0x0fc, reset zero
// [RULE10] target = extended above base; reserved zero
`timescale 1ns/100ps
`default_nettype none
`include "icw_consts.svh"

module icw_window (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    // configuration access from the function's decoder
    input  wire logic         cfg_req_in,
    input  wire logic         cfg_wr_in,
    input  wire logic         cfg_smbus_in,
    input  wire logic [11:0]  cfg_addr_in,
    input  wire logic [3:0]   cfg_be_in,
    input  wire logic [31:0]  cfg_wdata_in,
    output logic              cfg_hit_out,
    output logic              cfg_ack_out,
    output logic [31:0]       cfg_rdata_out,
    // forwarded access to the configuration register file
    output logic              tgt_req_out,
    output logic              tgt_wr_out,
    output logic [9:0]        tgt_dword_out,
    output logic [3:0]        tgt_be_out,
    output logic [31:0]       tgt_wdata_out,
    input  wire logic         tgt_ack_in,
    input  wire logic [31:0]  tgt_rdata_in
);
    icw_pkg::icw_state_t state;
    icw_pkg::icw_state_t next_state;
    logic [31:0] ptr_value;
    logic [9:0]  ptr_dword;
    logic        hit_ptr;
    logic        hit_data;
    logic        ptr_wr;
    logic        next_tgt_req;
    logic        next_tgt_wr;
    logic [3:0]  next_tgt_be;
    logic [31:0] next_tgt_wdata;
    logic [9:0]  next_tgt_dword;
    logic        next_ack;
    logic [31:0] next_rdata;
    logic [31:0] lane_rdata;

    assign hit_ptr  = cfg_addr_in == `ICW_PTR_OFFSET; // RULE9
    assign hit_data = cfg_addr_in == `ICW_DATA_OFFSET; // RULE9
    assign cfg_hit_out = hit_ptr | hit_data;
    assign ptr_wr = (state == icw_pkg::ICW_IDLE) && cfg_req_in && cfg_wr_in && hit_ptr;

    icw_pointer_reg u_ptr (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .wr_in      (ptr_wr),
        .be_in      (cfg_be_in),
        .wdata_in   (cfg_wdata_in),
        .ptr_out    (ptr_value),
        .dword_out  (ptr_dword)
    );

    // unenabled lanes read back zero so stale target bytes never leak out
    for (genvar g = 0; g < 4; g++) begin : g_lane
        assign lane_rdata[g*8 +: 8] = tgt_be_out[g] ? tgt_rdata_in[g*8 +: 8] : 8'h00; // RULE7
        AST_LANE_OFF: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE7
            state == icw_pkg::ICW_FWD && tgt_ack_in && !tgt_wr_out && !tgt_be_out[g]
            |=> cfg_rdata_out[g*8 +: 8] == 8'h00)
            else $error("disabled lane not zero");
    end

    // one access in flight; requester waits for ack before the next
    always_comb begin
        next_state     = state;
        next_tgt_req   = 1'b0;
        next_tgt_wr    = tgt_wr_out;
        next_tgt_be    = tgt_be_out;
        next_tgt_wdata = tgt_wdata_out;
        next_tgt_dword = tgt_dword_out;
        next_ack       = 1'b0;
        next_rdata     = cfg_rdata_out;
        unique case (state)
            icw_pkg::ICW_IDLE: begin
                if (cfg_req_in && cfg_hit_out) begin
                    if (hit_ptr) begin
                        next_ack   = 1'b1;
                        next_rdata = ptr_value; // RULE10
                        next_state = icw_pkg::ICW_DONE;
                    end else if (cfg_smbus_in) begin
                        // smbus path never reaches the target
                        next_ack   = 1'b1;
                        next_rdata = 32'h0000_0000; // RULE8
                        next_state = icw_pkg::ICW_DONE;
                    end else begin
                        next_tgt_req   = 1'b1;
                        next_tgt_wr    = cfg_wr_in; // RULE6
                        next_tgt_be    = cfg_be_in; // RULE7
                        next_tgt_wdata = cfg_wdata_in; // RULE6
                        // pointing at the window itself is undefined; not guarded
                        next_tgt_dword = ptr_dword; // RULE3 RULE4
                        next_state     = icw_pkg::ICW_FWD;
                    end
                end
            end
            icw_pkg::ICW_FWD: begin
                next_tgt_req = ~tgt_ack_in;
                if (tgt_ack_in) begin
                    next_ack   = 1'b1;
                    next_rdata = lane_rdata; // RULE5 RULE7
                    if (tgt_wr_out) begin
                        next_rdata = 32'h0000_0000;
                    end
                    next_state = icw_pkg::ICW_DONE;
                end
            end
            icw_pkg::ICW_DONE: begin
                next_state = icw_pkg::ICW_IDLE;
            end
        endcase
    end

    // every output except the hit flag leaves from here, so the requester sees no glitches
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state         <= icw_pkg::ICW_IDLE;
            tgt_req_out   <= 1'b0;
            tgt_wr_out    <= 1'b0;
            tgt_be_out    <= 4'h0;
            tgt_wdata_out <= `ICW_DATA_RESET;
            tgt_dword_out <= 10'h000;
            cfg_ack_out   <= 1'b0;
            cfg_rdata_out <= 32'h0000_0000;
        end else begin
            state         <= next_state;
            tgt_req_out   <= next_tgt_req;
            tgt_wr_out    <= next_tgt_wr;
            tgt_be_out    <= next_tgt_be;
            tgt_wdata_out <= next_tgt_wdata;
            tgt_dword_out <= next_tgt_dword;
            cfg_ack_out   <= next_ack;
            cfg_rdata_out <= next_rdata;
        end
    end

    // pointer: each field follows only its own byte lane
    AST_PTR_FIELDS: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE1
        ptr_wr && cfg_be_in == 4'hf |=> ptr_dword == {$past(cfg_wdata_in[11:8]), $past(cfg_wdata_in[7:2])})
        else $error("pointer did not capture fields");
    AST_BASE_KEEP: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE1
        ptr_wr && !cfg_be_in[0] |=> ptr_dword[5:0] == $past(ptr_dword[5:0]))
        else $error("base number changed without lane");
    AST_EXT_KEEP: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE2
        ptr_wr && !cfg_be_in[1] |=> ptr_dword[9:6] == $past(ptr_dword[9:6]))
        else $error("extended number changed without lane");
    AST_RSVD_ZERO: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE10
        ptr_value[31:12] == 20'h00000 && ptr_value[1:0] == 2'h0)
        else $error("reserved pointer bits nonzero");
    AST_PTR_READ: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE10
        state == icw_pkg::ICW_IDLE && cfg_req_in && hit_ptr
        |=> cfg_ack_out && cfg_rdata_out == $past(ptr_value) && !tgt_req_out)
        else $error("pointer access answered wrongly");

    // forwarded accesses: the target sees one steady request per non-smbus data-port access
    AST_FWD_ADDR: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE10
        $rose(tgt_req_out) |-> tgt_dword_out == $past(ptr_dword))
        else $error("forwarded dword mismatch");
    AST_FWD_BE: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE7
        state == icw_pkg::ICW_IDLE && cfg_req_in && hit_data && !cfg_smbus_in
        |=> tgt_req_out && tgt_be_out == $past(cfg_be_in) && tgt_wr_out == $past(cfg_wr_in))
        else $error("byte enables not forwarded");
    AST_TGT_HOLD: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE7
        tgt_req_out && !tgt_ack_in
        |=> tgt_req_out && $stable(tgt_wr_out) && $stable(tgt_dword_out)
            && $stable(tgt_be_out) && $stable(tgt_wdata_out))
        else $error("target request changed while waiting");
    AST_READ_DATA: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE5
        state == icw_pkg::ICW_FWD && tgt_ack_in && !tgt_wr_out && tgt_be_out == 4'hf
        |=> cfg_ack_out && cfg_rdata_out == $past(tgt_rdata_in))
        else $error("read data not returned");
    AST_WRITE_DATA: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE6
        state == icw_pkg::ICW_IDLE && cfg_req_in && hit_data && !cfg_smbus_in && cfg_wr_in
        |=> tgt_wr_out && tgt_wdata_out == $past(cfg_wdata_in))
        else $error("write data lost");
    AST_WRITE_ACK: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE6
        state == icw_pkg::ICW_FWD && tgt_ack_in && tgt_wr_out |=> cfg_ack_out && cfg_rdata_out == 32'h0000_0000)
        else $error("write completion wrong");
    AST_WRITE_ONCE: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE6
        tgt_req_out && tgt_ack_in |=> !tgt_req_out)
        else $error("target request repeated after ack");

    // smbus, unmapped offsets and reset
    AST_SMBUS: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE8
        state == icw_pkg::ICW_IDLE && cfg_req_in && hit_data && cfg_smbus_in
        |=> cfg_ack_out && cfg_rdata_out == 32'h0000_0000 && !tgt_req_out ##1 !tgt_req_out)
        else $error("smbus access reached target");
    AST_SMBUS_KEEP: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE8
        state == icw_pkg::ICW_IDLE && cfg_req_in && hit_data && cfg_smbus_in && cfg_wr_in
        |=> $stable(ptr_value))
        else $error("smbus write changed pointer");
    AST_NO_HIT: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RULE9
        state == icw_pkg::ICW_IDLE && cfg_req_in && !cfg_hit_out |=> !cfg_ack_out && !tgt_req_out)
        else $error("unmapped offset answered");
    AST_RESET: assert property (@(posedge clk_in) // RULE9
        sys_rst_in |=> ptr_value == `ICW_PTR_RESET && !tgt_req_out)
        else $error("reset values wrong");

    // main scenarios
    COV_READ: cover property (@(posedge clk_in) disable iff (sys_rst_in)
        tgt_req_out && !tgt_wr_out ##[1:20] cfg_ack_out);
    COV_WRITE: cover property (@(posedge clk_in) disable iff (sys_rst_in)
        tgt_req_out && tgt_wr_out ##[1:20] cfg_ack_out);
    COV_SMBUS: cover property (@(posedge clk_in) disable iff (sys_rst_in)
        cfg_req_in && hit_data && cfg_smbus_in);
    COV_PTR: cover property (@(posedge clk_in) disable iff (sys_rst_in) ptr_wr);
    COV_PART_READ: cover property (@(posedge clk_in) disable iff (sys_rst_in)
        state == icw_pkg::ICW_FWD && tgt_ack_in && !tgt_wr_out && tgt_be_out != 4'hf);
endmodule
`default_nettype wire

// ==== tb/icw_window_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "icw_consts.svh"
module icw_window_test;
    logic                 clk_in, sys_rst_in, cfg_req_in, cfg_wr_in, cfg_smbus_in, tgt_ack_in;
    logic [11:0]          cfg_addr_in;
    icw_pkg::icw_be_t     cfg_be_in, be;
    icw_pkg::icw_word_t   cfg_wdata_in, tgt_rdata_in, cfg_rdata_out, tgt_wdata_out, wd, ptr, resp;
    logic                 cfg_hit_out, cfg_ack_out, tgt_req_out, tgt_wr_out;
    icw_pkg::icw_dword_t  tgt_dword_out;
    icw_pkg::icw_be_t     tgt_be_out;
    icw_pkg::icw_word_t   rq[$];
    logic [46:0]          tq[$];
    int                   failures, n_checks, n, wait_cnt;
    icw_window dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cfg_req_in(cfg_req_in), .cfg_wr_in(cfg_wr_in),
        .cfg_smbus_in(cfg_smbus_in), .cfg_addr_in(cfg_addr_in), .cfg_be_in(cfg_be_in), .cfg_wdata_in(cfg_wdata_in),
        .cfg_hit_out(cfg_hit_out), .cfg_ack_out(cfg_ack_out), .cfg_rdata_out(cfg_rdata_out),
        .tgt_req_out(tgt_req_out), .tgt_wr_out(tgt_wr_out), .tgt_dword_out(tgt_dword_out),
        .tgt_be_out(tgt_be_out), .tgt_wdata_out(tgt_wdata_out), .tgt_ack_in(tgt_ack_in), .tgt_rdata_in(tgt_rdata_in));
    initial begin
        clk_in = 0;
        forever #12.5 clk_in = ~clk_in;
    end
    function automatic icw_pkg::icw_word_t lanes(icw_pkg::icw_be_t b);
        return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    endfunction
    task automatic chk(input string what, input logic [46:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error: %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // one access; the expected read data goes on the queue for the monitor
    task automatic access(input logic w, s, input logic [11:0] a, input icw_pkg::icw_be_t b,
                          input icw_pkg::icw_word_t d, e);
        int i;
        @(negedge clk_in);
        {cfg_req_in, cfg_wr_in, cfg_smbus_in, cfg_addr_in, cfg_be_in, cfg_wdata_in} = {1'b1, w, s, a, b, d};
        rq.push_back(e);
        for (i = 0; i < 40; i++) begin
            @(negedge clk_in);
            if (cfg_ack_out === 1'b1) break;
        end
        if (i == 40) chk("cfg_ack_out", 47'h1, 47'h0);
        cfg_req_in = 0;
        cfg_wdata_in = ~d;
        @(negedge clk_in);
    endtask
    always @(negedge clk_in) begin
        if (cfg_ack_out === 1'b1) begin
            if (rq.size() == 0) chk("unexpected cfg_ack_out", 47'h0, 47'h1);
            else chk("cfg_rdata_out", 47'(rq.pop_front()), 47'(cfg_rdata_out));
        end
    end
    // register file stand-in: varies its answer delay, scrambles read data outside the ack
    initial begin
        tgt_ack_in = 0;
        tgt_rdata_in = 0;
        wait_cnt = 0;
        forever begin
            @(negedge clk_in);
            if (tgt_ack_in) begin
                tgt_ack_in = 0;
                tgt_rdata_in = ~resp;
            end else if (tgt_req_out === 1'b1 && wait_cnt == 0) begin
                if (tq.size() == 0) chk("unexpected tgt_req_out", 47'h0, 47'h1);
                else chk("target access", tq.pop_front(), {tgt_wr_out, tgt_dword_out, tgt_be_out,
                         tgt_wr_out ? tgt_wdata_out : 32'h0});
                tgt_ack_in = 1;
                tgt_rdata_in = resp;
                wait_cnt = $urandom_range(0, 3);
            end else begin
                if (tgt_req_out === 1'b1) wait_cnt--;
                tgt_rdata_in = ~resp;
            end
        end
    end
    initial begin
        #(25 * 20000);
        chk("watchdog", 47'h0, 47'h1);
        complete_run;
    end
    initial begin
        {sys_rst_in, cfg_req_in, cfg_wr_in, cfg_smbus_in, cfg_addr_in, cfg_be_in, cfg_wdata_in} = '0;
        sys_rst_in = 1;
        ptr = `ICW_PTR_RESET;
        resp = 0;
        void'($urandom(1));
        repeat (12) @(negedge clk_in);
        sys_rst_in = 0;
        access(0, 0, `ICW_PTR_OFFSET, 4'hf, 0, `ICW_PTR_RESET);
        tq.push_back({1'b0, 10'h000, 4'hf, 32'h0});
        access(0, 0, `ICW_DATA_OFFSET, 4'hf, 0, resp);
        $display("reset test done");
        for (n = 0; n < 8; n++) begin
            be = $urandom_range(1, 15);
            wd = $urandom;
            if (n == 0) be[1] = 1'b1;
            wd[8] = 1'b1;
            access(1, 0, `ICW_PTR_OFFSET, be, wd, ptr & 32'h0000_0ffc);
            if (be[0]) ptr[7:2] = wd[7:2];
            if (be[1]) ptr[11:8] = wd[11:8];
            access(0, 0, `ICW_PTR_OFFSET, 4'hf, $urandom, ptr & 32'h0000_0ffc);
            be = $urandom_range(1, 15);
            resp = $urandom;
            tq.push_back({1'b0, ptr[11:8], ptr[7:2], be, 32'h0});
            access(0, 0, `ICW_DATA_OFFSET, be, $urandom, resp & lanes(be));
            be = $urandom_range(1, 15);
            wd = $urandom;
            tq.push_back({1'b1, ptr[11:8], ptr[7:2], be, wd});
            access(1, 0, `ICW_DATA_OFFSET, be, wd, 0);
            access(0, 1, `ICW_DATA_OFFSET, 4'hf, $urandom, 0);
            access(1, 1, `ICW_DATA_OFFSET, 4'hf, $urandom, 0);
            $display("window pass %0d done", n);
        end
        @(negedge clk_in);
        {cfg_req_in, cfg_addr_in} = {1'b1, 12'h0f4};
        #1 chk("cfg_hit_out", 47'h0, 47'(cfg_hit_out));
        repeat (10) @(negedge clk_in);
        cfg_req_in = 0;
        $display("unmapped address test done");
        repeat (5) @(negedge clk_in);
        complete_run;
    end
endmodule
`default_nettype wire
